// ==== core/adsq_pkg.sv ====
// Constants, offsets and types of the converter sequencing control.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package adsq_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TAD_MIN_NS    = 76;
  localparam int TAD_CYC       = (TAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TAD      = 12;
  localparam int SAMPLE_ENABLE_TAD      = 2;
  localparam int CONV_CYC      = CONV_TAD * TAD_CYC;
  localparam int SAMPLE_ENABLE_CYC      = SAMPLE_ENABLE_TAD * TAD_CYC;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL1    = 12'h000;
  localparam logic [11:0] OFS_CTRL2    = 12'h004;
  localparam logic [11:0] OFS_SCAN_LO  = 12'h008;
  localparam logic [11:0] OFS_SCAN_HI  = 12'h00C;
  localparam logic [11:0] OFS_PCFG     = 12'h010;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h018;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h01C;
  localparam logic [11:0] OFS_BUF_BASE = 12'h040;
  // First control register fields
  localparam int B_MODULE_ON  = 15;
  localparam int B_STOP_IDLE  = 13;
  localparam int B_DMA_ORDER  = 12;
  localparam int B_RES_SEL    = 10;
  localparam int B_FORM_LO    = 8;
  localparam int B_TRIG_LO    = 5;
  localparam int B_SIMULTANEOUS_SAMPLING     = 3;
  localparam int B_AUTO_SAMPLE_ENABLE  = 2;
  localparam int B_SAMPLE     = 1;
  localparam int B_DONE       = 0;
  localparam logic [15:0] CTRL1_MASK  = 16'hB7EF;
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  // Second control register fields
  localparam int B_CHAN_LO = 11;
  localparam int B_SCAN    = 10;
  localparam int B_SMPI_LO = 2;
  localparam logic [15:0] CTRL2_MASK  = 16'hFC3C;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  // Trigger codes
  localparam logic [2:0] TRIG_SW   = 3'h0;
  localparam logic [2:0] TRIG_EXT  = 3'h1;
  localparam logic [2:0] TRIG_T3   = 3'h2;
  localparam logic [2:0] TRIG_T5   = 3'h4;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // Interrupt status bits
  localparam int IRQ_GROUP = 0;
  localparam int IRQ_CONV  = 1;
  localparam int IRQ_W     = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_SAMPLE, ST_CONV} adsq_state_t;
endpackage

// ==== core/adsq_top.sv ====
// Converter sequencing control: registers, sequencer, result buffers, DMA hand-off.
// Assumes an AXI4-Lite master, an analog core that presents conv_data at the end
// of conversion, and trigger inputs synchronous to clk.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module adsq_top #(
  parameter int HAS_DMA      = 0,
  parameter int NPIN         = 16,
  parameter int DMA_SLOT_W   = 2
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [11:0]           s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [11:0]           s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [31:0]                s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  input  wire logic                  idle_mode,
  input  wire logic                  fifth_timer_match,
  input  wire logic                  third_timer_match,
  input  wire logic                  external_interrupt_pin,
  input  wire logic [11:0]           conv_data,
  input  wire logic [NPIN-1:0]       pin_in,
  input  wire logic [NPIN-1:0]       other_digital_config,
  output logic                       analog_on,
  output logic                       sample_hold,
  output logic                       convert_go,
  output logic [4:0]                 channel_sel,
  output logic                       irq,
  output logic                       dma_req,
  output logic [4+DMA_SLOT_W:0]      dma_addr,
  output logic [15:0]                dma_data,
  output logic [NPIN-1:0]            pin_buf_enable,
  output logic [NPIN-1:0]            digital_in
);
  localparam int NBUF  = (HAS_DMA != 0) ? 1 : 16;
  localparam int IRQ_W = adsq_pkg::IRQ_W;

  // Register state
  logic [15:0]               ctrl1_ff;
  logic [15:0]               ctrl2_ff;
  logic [15:0]               scan_lo_ff;
  logic [15:0]               scan_hi_ff;
  logic [15:0]               pcfg_ff;
  logic [IRQ_W-1:0]          stat_ff;
  logic [IRQ_W-1:0]          en_ff;
  logic [15:0]               buf_ff [NBUF];
  // Bus state
  logic                      aw_got_ff;
  logic                      w_got_ff;
  logic [11:0]               awaddr_ff;
  logic [31:0]               wdata_ff;
  logic [3:0]                wstrb_ff;
  // Sequencer state
  adsq_pkg::adsq_state_t     st_ff;
  logic                      sample_ff;
  logic                      done_ff;
  logic [7:0]                cnt_ff;
  logic [3:0]                grp_ff;
  logic [3:0]                ptr_ff;
  logic [DMA_SLOT_W-1:0]     round_ff;
  logic [4:0]                chan_ff;
  logic                      ext_q_ff;
  logic                      dma_req_ff;
  logic [4+DMA_SLOT_W:0]     dma_addr_ff;
  logic                      irq_ff;
  logic [NPIN-1:0]           pbe_ff;
  logic [NPIN-1:0]           din_ff;
  // Decoded controls and events
  logic                      wr_en;
  logic                      wr_ctrl1;
  logic [15:0]               wr_val;
  logic                      on;
  logic                      run;
  logic [2:0]                trig_sel;
  logic                      trig;
  logic                      conv_end;
  logic                      grp_end;
  logic [3:0]                smpi;
  logic [31:0]               scan_mask;
  logic [15:0]               result;
  logic [IRQ_W-1:0]          nxt_stat;
  logic [IRQ_W-1:0]          nxt_en;
  logic                      an_on_ff;
  logic                      conv_go_ff;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] adsq_merge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
    adsq_merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // Next set bit of the scan mask at or after a start index
  function automatic logic [4:0] adsq_next(input logic [31:0] m, input logic [4:0] s);
    logic [4:0] r;
    logic       f;
    r = s;
    f = 1'b0;
    for (int i = 0; i < 32; i++) begin
      logic [4:0] k;
      k = s + 5'(i);
      if (!f && m[k]) begin
        r = k;
        f = 1'b1;
      end
    end
    return r;
  endfunction

  // Output data format for both resolutions
  function automatic logic [15:0] adsq_fmt(input logic [11:0] d, input logic r12, input logic [1:0] f);
    logic [15:0] v;
    v = 16'h0000;
    if (r12) begin
      case (f)
        2'h0:    v = {4'h0, d};
        2'h1:    v = {{5{~d[11]}}, d[10:0]};
        2'h2:    v = {d, 4'h0};
        default: v = {~d[11], d[10:0], 4'h0};
      endcase
    end else begin
      case (f)
        2'h0:    v = {6'h00, d[9:0]};
        2'h1:    v = {{7{~d[9]}}, d[8:0]};
        2'h2:    v = {d[9:0], 6'h00};
        default: v = {~d[9], d[8:0], 6'h00};
      endcase
    end
    return v;
  endfunction

  // Control decode
  assign on        = ctrl1_ff[adsq_pkg::B_MODULE_ON];
  assign run       = on && !(ctrl1_ff[adsq_pkg::B_STOP_IDLE] && idle_mode);
  assign trig_sel  = ctrl1_ff[adsq_pkg::B_TRIG_LO +: 3];
  assign smpi      = ctrl2_ff[adsq_pkg::B_SMPI_LO +: 4];
  assign scan_mask = {scan_hi_ff, scan_lo_ff};
  assign wr_en     = aw_got_ff && w_got_ff && !s_bvalid;
  assign wr_ctrl1  = wr_en && (awaddr_ff == adsq_pkg::OFS_CTRL1);
  assign wr_val    = adsq_merge(ctrl1_ff, wdata_ff, wstrb_ff);
  // Enable value after this cycle, so the interrupt level follows a new enable at once
  assign nxt_en    = (wr_en && awaddr_ff == adsq_pkg::OFS_IRQ_EN && wstrb_ff[0]) ? wdata_ff[IRQ_W-1:0] : en_ff;
  assign conv_end  = run && (st_ff == adsq_pkg::ST_CONV) && (cnt_ff == 8'(adsq_pkg::CONV_CYC - 1));
  assign grp_end   = conv_end && (grp_ff == smpi);
  assign result    = adsq_fmt(conv_data, ctrl1_ff[adsq_pkg::B_RES_SEL], ctrl1_ff[adsq_pkg::B_FORM_LO +: 2]);

  // Trigger that ends sampling
  always_comb begin
    case (trig_sel)
      adsq_pkg::TRIG_AUTO: trig = (cnt_ff >= 8'(adsq_pkg::SAMPLE_ENABLE_CYC - 1));
      adsq_pkg::TRIG_SW:   trig = wr_ctrl1 && !wr_val[adsq_pkg::B_SAMPLE];
      adsq_pkg::TRIG_T5:   trig = fifth_timer_match;
      adsq_pkg::TRIG_T3:   trig = third_timer_match;
      adsq_pkg::TRIG_EXT:  trig = external_interrupt_pin && !ext_q_ff;
      default:             trig = 1'b0;
    endcase
  end

  // Write address and data capture, write response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= adsq_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_en) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (awaddr_ff[1:0] == 2'h0 && awaddr_ff < adsq_pkg::OFS_IRQ_CLR + 12'h004)
                    ? adsq_pkg::RESP_OKAY : adsq_pkg::RESP_DECERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= adsq_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= adsq_pkg::RESP_OKAY;
      s_rdata   <= 32'h0000_0000;
      if (s_araddr[1:0] != 2'h0) begin
        s_rresp <= adsq_pkg::RESP_DECERR;
      end else if (s_araddr >= adsq_pkg::OFS_BUF_BASE && s_araddr < adsq_pkg::OFS_BUF_BASE + 12'(4 * NBUF)) begin
        s_rdata <= {16'h0000, buf_ff[4'(s_araddr[5:2])]};
      end else begin
        case (s_araddr)
          adsq_pkg::OFS_CTRL1:    s_rdata <= {16'h0000, ctrl1_ff[15:2], sample_ff, done_ff};
          adsq_pkg::OFS_CTRL2:    s_rdata <= {16'h0000, ctrl2_ff};
          adsq_pkg::OFS_SCAN_LO:  s_rdata <= {16'h0000, scan_lo_ff};
          adsq_pkg::OFS_SCAN_HI:  s_rdata <= {16'h0000, scan_hi_ff};
          adsq_pkg::OFS_PCFG:     s_rdata <= {16'h0000, pcfg_ff};
          adsq_pkg::OFS_IRQ_STAT: s_rdata <= {30'h0000_0000, stat_ff};
          adsq_pkg::OFS_IRQ_EN:   s_rdata <= {30'h0000_0000, en_ff};
          adsq_pkg::OFS_IRQ_CLR:  s_rdata <= 32'h0000_0000;
          default:                s_rresp <= adsq_pkg::RESP_DECERR;
        endcase
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Software-owned configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_ff   <= adsq_pkg::CTRL1_RESET;
      ctrl2_ff   <= adsq_pkg::CTRL2_RESET;
      scan_lo_ff <= 16'h0000;
      scan_hi_ff <= 16'h0000;
      pcfg_ff    <= 16'h0000;
      en_ff      <= '0;
    end else if (wr_en) begin
      case (awaddr_ff)
        adsq_pkg::OFS_CTRL1:   ctrl1_ff   <= wr_val & adsq_pkg::CTRL1_MASK;
        adsq_pkg::OFS_CTRL2:   ctrl2_ff   <= adsq_merge(ctrl2_ff, wdata_ff, wstrb_ff) & adsq_pkg::CTRL2_MASK;
        adsq_pkg::OFS_SCAN_LO: scan_lo_ff <= adsq_merge(scan_lo_ff, wdata_ff, wstrb_ff);
        adsq_pkg::OFS_SCAN_HI: scan_hi_ff <= adsq_merge(scan_hi_ff, wdata_ff, wstrb_ff);
        adsq_pkg::OFS_PCFG:    pcfg_ff    <= adsq_merge(pcfg_ff, wdata_ff, wstrb_ff);
        adsq_pkg::OFS_IRQ_EN:  en_ff      <= wstrb_ff[0] ? wdata_ff[IRQ_W-1:0] : en_ff;
        default:               ;
      endcase
    end
  end
  // Sequencer: off, waiting, sampling, converting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= adsq_pkg::ST_OFF;
      sample_ff <= 1'b0;
      cnt_ff    <= 8'h00;
    end else if (!on) begin
      st_ff     <= adsq_pkg::ST_OFF;
      sample_ff <= 1'b0;
      cnt_ff    <= 8'h00;
    end else if (run) begin
      case (st_ff)
        adsq_pkg::ST_OFF: begin
          st_ff <= adsq_pkg::ST_WAIT;
        end
        adsq_pkg::ST_WAIT: begin
          if (ctrl1_ff[adsq_pkg::B_AUTO_SAMPLE_ENABLE] || (wr_ctrl1 && wr_val[adsq_pkg::B_SAMPLE])) begin
            st_ff     <= adsq_pkg::ST_SAMPLE;
            sample_ff <= 1'b1;
            cnt_ff    <= 8'h00;
          end
        end
        adsq_pkg::ST_SAMPLE: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (trig) begin
            st_ff     <= adsq_pkg::ST_CONV;
            sample_ff <= 1'b0;
            cnt_ff    <= 8'h00;
          end
        end
        adsq_pkg::ST_CONV: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (conv_end) begin
            st_ff     <= ctrl1_ff[adsq_pkg::B_AUTO_SAMPLE_ENABLE] ? adsq_pkg::ST_SAMPLE : adsq_pkg::ST_WAIT;
            sample_ff <= ctrl1_ff[adsq_pkg::B_AUTO_SAMPLE_ENABLE];
            cnt_ff    <= 8'h00;
          end
        end
        default: st_ff <= adsq_pkg::ST_OFF;
      endcase
    end
  end

  // Done flag: cleared at conversion start or by software, set on completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else if (conv_end) begin
      done_ff <= 1'b1;
    end else if (run && st_ff == adsq_pkg::ST_SAMPLE && trig) begin
      done_ff <= 1'b0;
    end else if (wr_ctrl1 && !wr_val[adsq_pkg::B_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // Conversion grouping, scan channel and buffer pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_ff   <= 4'h0;
      ptr_ff   <= 4'h0;
      round_ff <= '0;
      chan_ff  <= 5'h00;
    end else if (!on) begin
      grp_ff  <= 4'h0;
      ptr_ff  <= 4'h0;
      chan_ff <= ctrl2_ff[adsq_pkg::B_SCAN] ? adsq_next(scan_mask, 5'h00) : ctrl2_ff[adsq_pkg::B_CHAN_LO +: 5];
    end else if (conv_end) begin
      grp_ff <= grp_end ? 4'h0 : grp_ff + 4'h1;
      ptr_ff <= grp_end ? 4'h0 : ptr_ff + 4'h1;
      if (grp_end) begin
        round_ff <= round_ff + 1'b1;
      end
      if (ctrl2_ff[adsq_pkg::B_SCAN]) begin
        chan_ff <= grp_end ? adsq_next(scan_mask, 5'h00) : adsq_next(scan_mask, chan_ff + 5'h01);
      end
    end else if (!ctrl2_ff[adsq_pkg::B_SCAN]) begin
      chan_ff <= ctrl2_ff[adsq_pkg::B_CHAN_LO +: 5];
    end
  end

  // Result storage; stored results survive switching off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NBUF; i++) begin
        buf_ff[i] <= 16'h0000;
      end
    end else if (conv_end) begin
      if (HAS_DMA != 0) begin
        buf_ff[0] <= result;
      end else begin
        buf_ff[ptr_ff] <= result;
      end
    end
  end

  // DMA request and address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_ff  <= 1'b0;
      dma_addr_ff <= '0;
    end else begin
      dma_req_ff <= (HAS_DMA != 0) && conv_end;
      if (conv_end) begin
        dma_addr_ff <= ctrl1_ff[adsq_pkg::B_DMA_ORDER] ? {{(DMA_SLOT_W+1){1'b0}}, ptr_ff}
                                                       : {chan_ff, round_ff};
      end
    end
  end

  // Interrupt status, set wins over clear
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_en && awaddr_ff == adsq_pkg::OFS_IRQ_CLR && wstrb_ff[0]) begin
      nxt_stat = nxt_stat & ~wdata_ff[IRQ_W-1:0];
    end
    nxt_stat[adsq_pkg::IRQ_GROUP] = nxt_stat[adsq_pkg::IRQ_GROUP] | grp_end;
    nxt_stat[adsq_pkg::IRQ_CONV]  = nxt_stat[adsq_pkg::IRQ_CONV] | conv_end;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= '0;
      irq_ff  <= 1'b0;
      ext_q_ff <= 1'b0;
    end else begin
      stat_ff  <= nxt_stat;
      irq_ff   <= |(nxt_stat & nxt_en);
      ext_q_ff <= external_interrupt_pin;
    end
  end

  // Digital input buffers enabled only when both converters agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pbe_ff <= '0;
      din_ff <= '0;
    end else begin
      pbe_ff <= pcfg_ff[NPIN-1:0] & other_digital_config;
      din_ff <= pin_in & pcfg_ff[NPIN-1:0] & other_digital_config;
    end
  end

  // Analog core controls, registered off the sequencer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      an_on_ff   <= 1'b0;
      conv_go_ff <= 1'b0;
    end else begin
      an_on_ff   <= (st_ff != adsq_pkg::ST_OFF);
      conv_go_ff <= (st_ff == adsq_pkg::ST_CONV);
    end
  end

  assign analog_on      = an_on_ff;
  assign sample_hold    = sample_ff;
  assign convert_go     = conv_go_ff;
  assign channel_sel    = chan_ff;
  assign irq            = irq_ff;
  assign dma_req        = dma_req_ff;
  assign dma_addr       = dma_addr_ff;
  assign dma_data       = buf_ff[0];
  assign pin_buf_enable = pbe_ff;
  assign digital_in     = din_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_done_clear: assert property (run && st_ff == adsq_pkg::ST_SAMPLE && trig && !conv_end |=> !done_ff)
    else $error("done not cleared at conversion start");
  a_done_set: assert property (conv_end |=> done_ff && st_ff != adsq_pkg::ST_CONV)
    else $error("done not set at conversion end");
  a_off_abort: assert property (!on |=> st_ff == adsq_pkg::ST_OFF && !sample_ff)
    else $error("module off did not abort");
  a_idle_halt: assert property (on && !run |=> $stable(cnt_ff) && $stable(st_ff))
    else $error("sequencer moved during idle halt");
  a_group_irq: assert property (grp_end |=> stat_ff[adsq_pkg::IRQ_GROUP] && grp_ff == 4'h0)
    else $error("group flag missing");
  a_ptr_reset: assert property (grp_end |=> ptr_ff == 4'h0)
    else $error("buffer pointer not reset");
  a_ptr_step: assert property (conv_end && !grp_end |=> ptr_ff == $past(ptr_ff) + 4'h1)
    else $error("buffer pointer did not advance");
  a_auto_conv: assert property (run && st_ff == adsq_pkg::ST_SAMPLE && trig_sel == adsq_pkg::TRIG_AUTO
                                ##1 (run && st_ff == adsq_pkg::ST_SAMPLE)[*7] |-> ##1 st_ff == adsq_pkg::ST_CONV)
    else $error("auto-convert overran sample time");
  a_pin_gate: assert property (##1 digital_in == $past(pin_in & pcfg_ff[NPIN-1:0] & other_digital_config))
    else $error("digital input not gated");
  a_irq_level: assert property (##1 irq == |(stat_ff & en_ff))
    else $error("interrupt level wrong");
endmodule

// ==== tb/adsq_partner.sv ====
// Analog core model: hands the sequencer one result per conversion.
// Assumes convert_go stays high through the last conversion cycle.
`timescale 1ns/1ps
module adsq_partner (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        convert_go,
  output logic      [11:0] conv_data
);
  logic [7:0] cnt_ff;
  logic       go_ff;

  // Count finished conversions so every result differs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      go_ff  <= 1'b0;
    end else begin
      go_ff <= convert_go;
      if (go_ff && !convert_go) cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Outside a conversion the result lines are not valid, so show a changing pattern
  assign conv_data = convert_go ? 12'hB5A + 12'h131 * {4'h0, cnt_ff} : {cnt_ff, 4'hF} ^ {12{clk}};
endmodule

// ==== tb/adsq_top_tb_top.sv ====
// Directed bench for the converter sequencing control over AXI4-Lite.
// Assumes the analog core model adsq_partner and a 40 MHz clock.
`timescale 1ns/1ps
module adsq_top_tb_top;
  logic        clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, idle_mode;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, analog_on, sample_hold;
  logic        fifth_timer_match, third_timer_match, external_interrupt_pin, convert_go, irq, dma_req;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [3:0]  s_wstrb;
  logic [4:0]  channel_sel;
  logic [6:0]  dma_addr;
  logic [11:0] s_awaddr, s_araddr, conv_data;
  logic [15:0] dma_data, pin_in, other_digital_config, pin_buf_enable, digital_in, c;
  logic [31:0] s_wdata, s_rdata, v;
  int          err_total, tests_run, nconv;

  adsq_top dut (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .idle_mode, .fifth_timer_match, .third_timer_match, .external_interrupt_pin, .conv_data,
    .pin_in, .other_digital_config, .analog_on, .sample_hold, .convert_go, .channel_sel, .irq, .dma_req,
    .dma_addr, .dma_data, .pin_buf_enable, .digital_in);
  adsq_partner model (.clk, .rst_n, .convert_go, .conv_data);

  // Raw sample of conversion k and its formatted result word
  function automatic logic [11:0] smp(input int k);
    return 12'hB5A + 12'(k * 12'h131);
  endfunction
  function automatic logic [15:0] fmt(input logic [2:0] m, input logic [11:0] d);
    case (m)
      3'h0: return {6'h00, d[9:0]};
      3'h1: return {{7{~d[9]}}, d[8:0]};
      3'h2: return {d[9:0], 6'h00};
      3'h3: return {~d[9], d[8:0], 6'h00};
      3'h4: return {4'h0, d};
      3'h5: return {{5{~d[11]}}, d[10:0]};
      3'h6: return {d, 4'h0};
      default: return {~d[11], d[10:0], 4'h0};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      err_total++;
      $display("Error bus answer expected within 60 cycles got none");
      finish_test();
    end
  endtask
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= {16'h0000, d};
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    s_bready <= 1'b0;
    tmo(n);
  endtask
  // Read: result left in v and r
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    v = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    tmo(n);
  endtask
  // Poll the done bit a bounded number of times
  task automatic pd(input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(adsq_pkg::OFS_CTRL1);
      if (v[0]) break;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Main sequence
  initial begin
    {rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, idle_mode} = 7'h00;
    {fifth_timer_match, third_timer_match, external_interrupt_pin} = 3'h0;
    {s_awaddr, s_araddr, s_wdata} = 56'h0;
    s_wstrb = 4'hF;
    pin_in = 16'hFFFF;
    other_digital_config = 16'h0001;
    err_total = 0;
    tests_run = 0;
    nconv = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(adsq_pkg::OFS_CTRL1);
    chk("ctrl1 reset", 32'h0, v);
    rd(12'h020);
    chk("unmapped resp", 32'(adsq_pkg::RESP_DECERR), 32'(r));
    $display("test reset done");
    // Every format in both resolutions, software trigger; switch on first
    wr(adsq_pkg::OFS_CTRL1, 16'h8000);
    for (int m = 0; m < 8; m++) begin
      c = 16'h8000 | {5'h00, 3'(m), 8'h00};
      wr(adsq_pkg::OFS_CTRL1, c | 16'h0002);
      chk("sample bit", 32'h1, 32'(sample_hold));
      wr(adsq_pkg::OFS_CTRL1, c);
      pd(40);
      chk("done", 32'h1, 32'(v[0]));
      rd(adsq_pkg::OFS_BUF_BASE);
      chk("result", {16'h0000, fmt(3'(m), smp(nconv))}, v);
      nconv++;
    end
    $display("test formats done");
    // Hardware triggers and reserved codes
    for (int t = 1; t < 7; t++) begin
      wr(adsq_pkg::OFS_CTRL1, 16'h8002 | {8'h00, 3'(t), 5'h00});
      {fifth_timer_match, third_timer_match, external_interrupt_pin} <= 3'(t);
      repeat (2) @(posedge clk);
      {fifth_timer_match, third_timer_match, external_interrupt_pin} <= 3'h0;
      pd(30);
      chk("trigger", 32'(t == 1 || t == 2 || t == 4), 32'(v[0]));
      if (t == 1 || t == 2 || t == 4) nconv++;
    end
    $display("test triggers done");
    chk("irq masked", 32'h0, 32'(irq));
    rd(adsq_pkg::OFS_IRQ_STAT);
    chk("group status", 32'h1, 32'(v[adsq_pkg::IRQ_GROUP]));
    wr(adsq_pkg::OFS_IRQ_EN, 16'h0001);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(adsq_pkg::OFS_IRQ_CLR, 16'h0003);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(adsq_pkg::OFS_PCFG, 16'h0003);
    repeat (2) @(posedge clk);
    chk("buffer enable", 32'h1, 32'(pin_buf_enable));
    chk("digital in", 32'h1, 32'(digital_in));
    $display("test irq and pins done");
    // Auto-convert, interrupt after two conversions, then switch off
    wr(adsq_pkg::OFS_CTRL2, 16'h0004);
    wr(adsq_pkg::OFS_CTRL1, 16'h90E4);
    for (int i = 0; i < 400 && !irq; i++) @(posedge clk);
    chk("irq auto", 32'h1, 32'(irq));
    if (!irq) finish_test();
    chk("order addr", 32'h1, 32'(dma_addr));
    rd(adsq_pkg::OFS_BUF_BASE);
    chk("auto buf0", {16'h0000, fmt(3'h0, smp(nconv))}, v);
    rd(adsq_pkg::OFS_BUF_BASE + 12'h004);
    chk("auto buf1", {16'h0000, fmt(3'h0, smp(nconv + 1))}, v);
    chk("module on", 32'h1, 32'(analog_on));
    wr(adsq_pkg::OFS_CTRL1, 16'h0000);
    repeat (2) @(posedge clk);
    chk("module off", 32'h0, 32'(analog_on));
    chk("convert off", 32'h0, 32'(convert_go));
    rd(adsq_pkg::OFS_BUF_BASE + 12'h004);
    chk("kept buf1", {16'h0000, fmt(3'h0, smp(nconv + 1))}, v);
    $display("test auto done");
    // Scan list 1,2,4 with two conversions a group, started under idle halt
    wr(adsq_pkg::OFS_IRQ_CLR, 16'h0003);
    wr(adsq_pkg::OFS_SCAN_LO, 16'h0016);
    wr(adsq_pkg::OFS_CTRL2, 16'h0404);
    repeat (2) @(posedge clk);
    chk("scan first", 32'h1, 32'(channel_sel));
    idle_mode <= 1'b1;
    wr(adsq_pkg::OFS_CTRL1, 16'hA0E4);
    repeat (60) @(posedge clk);
    chk("idle halt", 32'h0, 32'(analog_on));
    idle_mode <= 1'b0;
    for (int i = 0; i < 400 && !irq; i++) @(posedge clk);
    chk("irq scan", 32'h1, 32'(irq));
    chk("scan restart", 32'h1, 32'(channel_sel));
    chk("scatter addr", 32'h08, 32'(dma_addr));
    $display("test scan and idle done");
    finish_test();
  end
endmodule
